// ### rtl/t16_timer.sv
// Functional notes
// - event mode counts each qualified trigger edge
// - primary match clears count, raises primary request
// - trigger edge rising, falling or both
// - two matching samples qualify trigger edges
// - enable plus invert toggles pin on match
// - count clock: trigger, main division, watch
// - software trigger bit clears and starts counter
// - pulse on at secondary, off at primary
// - counter keeps running until mode cleared
// - trigger edge clears, starts, begins pulse
// - trigger edges ignored during active pulse
// - zero mode bits stop, nonzero starts
// - first match may be one count early/late
// - lowered primary: wrap through overflow first
// - capture during read keeps data, flags edge
// - overflow flag on FFFFH to 0000H roll
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module t16_timer import t16_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger_in,
	input wire logic watch_tick,
	output logic timer_out_pin,
	output logic primary_match_irq,
	output logic secondary_match_irq,
	output logic ext_edge_irq
);
	// all block state
	typedef struct packed {
		logic [15:0] count_reg;
		logic [15:0] primary_compare;
		logic [15:0] secondary_compare;
		logic [2:0] op_mode;
		logic overflow_flag;
		logic capture_mode;
		logic [2:0] output_ctrl;
		logic [1:0] edge_sel;
		logic [4:0] clk_sel;
		logic [1:0] sample_clock_select;
		t16_os_e os_state;
		logic out_level;
		logic pin;
		logic pm_irq;
		logic sm_irq;
		logic edge_irq;
		logic [31:0] prdata;
	} t16_state_s;
	t16_state_s s_r, s_nxt;

	logic qual_edge; // filtered trigger edge
	logic count_tick; // one count clock
	logic setup_ph; // apb setup cycle
	logic wr_en; // apb write takes effect
	logic hit_any; // mapped address
	logic rd_sec; // secondary register being read
	logic sw_trig; // software one-shot trigger
	logic trig_start; // trigger edge restarts counter
	logic running; // mode bits nonzero
	logic oneshot_en; // one-shot output selected
	logic pri_hit; // count equals primary compare
	logic sec_hit; // count equals secondary compare
	logic eng_step; // plain counting step
	logic [31:0] rd_mux; // read data selection

	// trigger pin noise filter
	t16_trig_filter u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.trig_in(ext_trigger_in),
		.sample_clock_select(s_r.sample_clock_select),
		.edge_sel(s_r.edge_sel),
		.edge_pulse(qual_edge)
	);

	// count clock generation
	t16_prescale u_prescale (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.src_sel(s_r.clk_sel[T16_SRC_LO +: 2]),
		.div_sel(s_r.clk_sel[T16_DIV_LO +: 2]),
		.osc_mode_bit(s_r.clk_sel[T16_MCS_POS]),
		.watch_tick(watch_tick),
		.ext_edge(qual_edge),
		.count_tick(count_tick)
	);

	// apb phase and address decode
	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite && hit_any;
	assign hit_any = t16_hit(paddr, T16_OFF_MODE) || t16_hit(paddr, T16_OFF_CAPCMP)
		|| t16_hit(paddr, T16_OFF_OUTCTL) || t16_hit(paddr, T16_OFF_EXTIRQ)
		|| t16_hit(paddr, T16_OFF_CLKSEL) || t16_hit(paddr, T16_OFF_SCS)
		|| t16_hit(paddr, T16_OFF_PRI) || t16_hit(paddr, T16_OFF_SEC)
		|| t16_hit(paddr, T16_OFF_COUNT);
	assign rd_sec = psel && !pwrite && t16_hit(paddr, T16_OFF_SEC);

	// control decode
	assign running = s_r.op_mode != T16_OP_STOP;
	assign oneshot_en = s_r.output_ctrl[T16_OSEN_POS];
	assign sw_trig = wr_en && t16_hit(paddr, T16_OFF_OUTCTL) && pwdata[T16_ONESHOT_SW_TRIGGER_POS]
		&& running;
	assign trig_start = qual_edge && s_r.op_mode == T16_OP_CLR_TRIG
		&& !(oneshot_en && s_r.os_state != T16_OS_IDLE);
	assign pri_hit = s_r.count_reg == s_r.primary_compare;
	assign sec_hit = !s_r.capture_mode && s_r.count_reg == s_r.secondary_compare;
	// start waits for next count clock
	assign eng_step = running && !sw_trig && !trig_start && count_tick;

	// read data selection, count read directly
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			T16_OFF_MODE: rd_mux[3:0] = {s_r.op_mode, s_r.overflow_flag};
			T16_OFF_CAPCMP: rd_mux[T16_CAP_POS] = s_r.capture_mode;
			T16_OFF_OUTCTL: rd_mux[2:0] = s_r.output_ctrl;
			T16_OFF_EXTIRQ: rd_mux[T16_ES_LO +: 2] = s_r.edge_sel;
			T16_OFF_CLKSEL: rd_mux[4:0] = s_r.clk_sel;
			T16_OFF_SCS: rd_mux[1:0] = s_r.sample_clock_select;
			T16_OFF_PRI: rd_mux[15:0] = s_r.primary_compare;
			T16_OFF_SEC: rd_mux[15:0] = s_r.secondary_compare;
			T16_OFF_COUNT: rd_mux[15:0] = s_r.count_reg;
			default: rd_mux = 32'h0;
		endcase
	end

	// next state: bus writes first, then hardware events
	always_comb begin
		s_nxt = s_r;
		s_nxt.pm_irq = 1'b0;
		s_nxt.sm_irq = 1'b0;
		s_nxt.edge_irq = 1'b0;
		// read data latched in the setup cycle
		if (setup_ph && !pwrite) begin
			s_nxt.prdata = rd_mux;
		end
		// register writes
		if (wr_en) begin
			case (paddr)
				T16_OFF_MODE: begin
					s_nxt.op_mode = pwdata[T16_OP_LO +: 3];
					// writing zero clears the overflow flag
					s_nxt.overflow_flag = s_r.overflow_flag && pwdata[T16_OVF_POS];
				end
				T16_OFF_CAPCMP: s_nxt.capture_mode = pwdata[T16_CAP_POS];
				T16_OFF_OUTCTL: s_nxt.output_ctrl = pwdata[2:0] & T16_OUTCTL_MASK[2:0];
				T16_OFF_EXTIRQ: s_nxt.edge_sel = pwdata[T16_ES_LO +: 2];
				T16_OFF_CLKSEL: s_nxt.clk_sel = pwdata[4:0];
				T16_OFF_SCS: s_nxt.sample_clock_select = pwdata[1:0];
				T16_OFF_PRI: s_nxt.primary_compare = pwdata[15:0];
				T16_OFF_SEC: s_nxt.secondary_compare = pwdata[15:0];
				default: s_nxt.prdata = s_nxt.prdata;
			endcase
		end
		// counting engine
		if (!running) begin
			s_nxt.count_reg = 16'h0;
			s_nxt.os_state = T16_OS_IDLE;
		end else if (sw_trig || trig_start) begin
			s_nxt.count_reg = 16'h0;
			s_nxt.os_state = oneshot_en ? T16_OS_ARMED : T16_OS_IDLE;
		end else if (count_tick) begin
			if (sec_hit) begin
				s_nxt.sm_irq = 1'b1;
			end
			case (s_r.os_state)
				T16_OS_ARMED: begin
					if (sec_hit) begin
						s_nxt.out_level = 1'b1;
						s_nxt.os_state = T16_OS_ACTIVE;
					end
				end
				T16_OS_ACTIVE: begin
					if (pri_hit) begin
						s_nxt.out_level = 1'b0;
						s_nxt.os_state = T16_OS_IDLE;
					end
				end
				default: s_nxt.os_state = T16_OS_IDLE;
			endcase
			if (pri_hit) begin
				s_nxt.pm_irq = 1'b1;
				if (!oneshot_en && s_r.output_ctrl[T16_OE_POS]
					&& s_r.output_ctrl[T16_INV_POS]) begin
					s_nxt.out_level = !s_r.out_level;
				end
			end
			if (s_r.count_reg == T16_CNT_MAX) begin
				s_nxt.overflow_flag = 1'b1;
			end
			if (pri_hit && s_r.op_mode == T16_OP_CLR_MATCH) begin
				s_nxt.count_reg = 16'h0;
			end else begin
				s_nxt.count_reg = s_r.count_reg + 16'h1;
			end
		end
		if (qual_edge) begin
			s_nxt.edge_irq = 1'b1;
			if (s_r.capture_mode && !rd_sec) begin
				s_nxt.secondary_compare = s_r.count_reg;
			end
		end
		// pin drives only while output enabled
		s_nxt.pin = s_nxt.out_level && s_nxt.output_ctrl[T16_OE_POS];
	end

	// state register with clock enable freeze
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.primary_compare <= T16_PRI_RST;
			s_r.os_state <= T16_OS_IDLE;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	assign timer_out_pin = s_r.pin;
	assign primary_match_irq = s_r.pm_irq;
	assign secondary_match_irq = s_r.sm_irq;
	assign ext_edge_irq = s_r.edge_irq;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_sw_fire;
		ce && sw_trig && oneshot_en;
	endsequence
	sequence s_armed_zero;
		s_r.count_reg == 16'h0 && s_r.os_state == T16_OS_ARMED;
	endsequence

	a_stop_zero: assert property (
		(ce && !running) |=> s_r.count_reg == 16'h0)
		else $error("count not held at zero while stopped");
	a_match_clear: assert property (
		(ce && eng_step && pri_hit && s_r.op_mode == T16_OP_CLR_MATCH)
		|=> s_r.count_reg == 16'h0 && primary_match_irq)
		else $error("primary match did not clear count");
	a_count_step: assert property (
		(ce && eng_step && !pri_hit)
		|=> s_r.count_reg == $past(s_r.count_reg) + 16'h1)
		else $error("count did not advance by one");
	a_ovf_roll: assert property (
		(ce && eng_step && s_r.count_reg == T16_CNT_MAX) |=> s_r.overflow_flag)
		else $error("overflow flag not set on roll");
	a_square_toggle: assert property (
		(ce && eng_step && pri_hit && !oneshot_en && s_r.output_ctrl[1:0] == 2'h3)
		|=> s_r.out_level != $past(s_r.out_level))
		else $error("square wave did not toggle");
	a_sw_start: assert property (
		s_sw_fire |=> s_armed_zero)
		else $error("software trigger did not clear and arm");
	a_pulse_on: assert property (
		(ce && eng_step && sec_hit && s_r.os_state == T16_OS_ARMED)
		|=> s_r.out_level ##0 secondary_match_irq)
		else $error("one-shot pulse not activated");
	a_pulse_off: assert property (
		(ce && eng_step && pri_hit && s_r.os_state == T16_OS_ACTIVE)
		|=> !s_r.out_level && s_r.os_state == T16_OS_IDLE && running)
		else $error("one-shot pulse not ended");
	a_trig_ignored: assert property (
		(ce && running && qual_edge && oneshot_en && s_r.os_state == T16_OS_ACTIVE
		&& !pri_hit && !sw_trig) |=> s_r.os_state == T16_OS_ACTIVE)
		else $error("trigger restarted an active pulse");
	a_capture_hold: assert property (
		(ce && qual_edge && s_r.capture_mode && rd_sec && !wr_en)
		|=> s_r.secondary_compare == $past(s_r.secondary_compare) && ext_edge_irq)
		else $error("capture not held during read");
	// stopped timer returns the one-shot to idle, out_level kept
	a_stop_idle: assert property (
		(ce && !running) |=> s_r.os_state == T16_OS_IDLE)
		else $error("one-shot not idle while stopped");
	// trigger edge clears and arms
	a_trig_arm: assert property (
		(ce && trig_start && oneshot_en) |=> s_armed_zero)
		else $error("trigger edge did not clear and arm");
	// pin low while output disabled
	a_pin_gate: assert property (
		!s_r.output_ctrl[T16_OE_POS] |-> !timer_out_pin)
		else $error("pin driven while output disabled");
	// every qualified edge flagged
	a_edge_flag: assert property (
		(ce && qual_edge) |=> ext_edge_irq)
		else $error("qualified edge not flagged");
	// capture outside a read
	a_capture_take: assert property (
		(ce && qual_edge && s_r.capture_mode && !rd_sec)
		|=> s_r.secondary_compare == $past(s_r.count_reg))
		else $error("count not captured on edge");
	// secondary match request pulse
	a_sec_request: assert property (
		(ce && eng_step && sec_hit) |=> secondary_match_irq)
		else $error("secondary match request missing");
	// overflow flag held until cleared
	a_ovf_hold: assert property (
		(ce && s_r.overflow_flag && !wr_en) |=> s_r.overflow_flag)
		else $error("overflow flag lost");
	// count read straight from the counter
	a_count_read: assert property (
		(ce && setup_ph && !pwrite && paddr == T16_OFF_COUNT)
		|=> prdata == {16'h0, $past(s_r.count_reg)})
		else $error("count register read wrong");
endmodule // t16_timer
`default_nettype wire

// ### rtl/t16_pkg.sv
package t16_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] T16_OFF_MODE = 8'h00;
	localparam logic [7:0] T16_OFF_CAPCMP = 8'h04;
	localparam logic [7:0] T16_OFF_OUTCTL = 8'h08;
	localparam logic [7:0] T16_OFF_EXTIRQ = 8'h0c;
	localparam logic [7:0] T16_OFF_CLKSEL = 8'h10;
	localparam logic [7:0] T16_OFF_SCS = 8'h14;
	localparam logic [7:0] T16_OFF_PRI = 8'h18;
	localparam logic [7:0] T16_OFF_SEC = 8'h1c;
	localparam logic [7:0] T16_OFF_COUNT = 8'h20;
	// timer_mode_reg fields
	localparam int T16_OVF_POS = 0;
	localparam int T16_OP_LO = 1;
	localparam logic [2:0] T16_OP_STOP = 3'h0;
	localparam logic [2:0] T16_OP_CLR_TRIG = 3'h4;
	localparam logic [2:0] T16_OP_CLR_MATCH = 3'h6;
	// capcmp_ctrl_reg: secondary register captures when set
	localparam int T16_CAP_POS = 0;
	// output_ctrl_reg fields
	localparam int T16_OE_POS = 0;
	localparam int T16_INV_POS = 1;
	localparam int T16_OSEN_POS = 2;
	localparam int T16_ONESHOT_SW_TRIGGER_POS = 6;
	// ext_irq_mode_reg edge select field and codes
	localparam int T16_ES_LO = 2;
	localparam logic [1:0] T16_ES_FALL = 2'h0;
	localparam logic [1:0] T16_ES_RISE = 2'h1;
	localparam logic [1:0] T16_ES_NONE = 2'h2;
	localparam logic [1:0] T16_ES_BOTH = 2'h3;
	// clock select register fields and source codes
	localparam int T16_SRC_LO = 0;
	localparam int T16_DIV_LO = 2;
	localparam int T16_MCS_POS = 4;
	localparam logic [1:0] T16_SRC_MAIN = 2'h0;
	localparam logic [1:0] T16_SRC_EXT = 2'h1;
	localparam logic [1:0] T16_SRC_WATCH = 2'h2;
	// reset value, count limit and write mask
	localparam logic [15:0] T16_PRI_RST = 16'hffff;
	localparam logic [15:0] T16_CNT_MAX = 16'hffff;
	localparam logic [7:0] T16_OUTCTL_MASK = 8'h07;
	// one-shot sequencer states
	typedef enum logic [1:0] {T16_OS_IDLE, T16_OS_ARMED, T16_OS_ACTIVE} t16_os_e;
	// true when an address selects a register
	function automatic logic t16_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction
endpackage

// ### rtl/t16_trig_filter.sv
`timescale 1ns/100ps
`default_nettype none
module t16_trig_filter import t16_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic trig_in,
	input wire logic [1:0] sample_clock_select,
	input wire logic [1:0] edge_sel,
	output logic edge_pulse
);
	// all filter state
	typedef struct packed {
		logic [2:0] div;
		logic samp_a;
		logic samp_b;
		logic level;
		logic pulse;
	} t16_flt_s;
	t16_flt_s f_r, f_nxt;
	logic samp_tick;

	// sample interval of 1, 2, 4 or 8 clocks
	assign samp_tick = (f_r.div & ((3'h1 << sample_clock_select) - 3'h1)) == 3'h0;

	// two equal samples of a new level qualify an edge
	always_comb begin
		f_nxt = f_r;
		f_nxt.div = f_r.div + 3'h1;
		f_nxt.pulse = 1'b0;
		if (samp_tick) begin
			f_nxt.samp_a = trig_in;
			f_nxt.samp_b = f_r.samp_a;
		end
		if (f_r.samp_a == f_r.samp_b && f_r.samp_a != f_r.level) begin
			f_nxt.level = f_r.samp_a;
			case (edge_sel)
				T16_ES_RISE: f_nxt.pulse = f_r.samp_a;
				T16_ES_FALL: f_nxt.pulse = !f_r.samp_a;
				T16_ES_BOTH: f_nxt.pulse = 1'b1;
				default: f_nxt.pulse = 1'b0;
			endcase
		end
	end

	// register with clock enable freeze
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f_r <= '0;
		end else if (ce) begin
			f_r <= f_nxt;
		end
	end

	assign edge_pulse = f_r.pulse;
endmodule // t16_trig_filter
`default_nettype wire

// ### rtl/t16_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module t16_prescale import t16_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [1:0] src_sel,
	input wire logic [1:0] div_sel,
	input wire logic osc_mode_bit,
	input wire logic watch_tick,
	input wire logic ext_edge,
	output logic count_tick
);
	// all prescaler state
	typedef struct packed {
		logic [3:0] div;
	} t16_pre_s;
	t16_pre_s p_r, p_nxt;
	logic [2:0] shift;

	// true when the low n bits of the divider are all ones
	function automatic logic t16_div_hit(input logic [3:0] cnt, input logic [2:0] n);
		logic [3:0] mask;
		mask = 4'((5'h1 << n) - 5'h1);
		return (cnt & mask) == mask;
	endfunction

	// slower main clock doubles every division
	assign shift = {1'b0, div_sel} + {2'h0, !osc_mode_bit};

	always_comb begin
		p_nxt = p_r;
		p_nxt.div = p_r.div + 4'h1;
	end

	always_comb begin
		case (src_sel)
			T16_SRC_MAIN: count_tick = t16_div_hit(p_r.div, shift);
			T16_SRC_EXT: count_tick = ext_edge;
			T16_SRC_WATCH: count_tick = watch_tick;
			default: count_tick = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_r <= '0;
		end else if (ce) begin
			p_r <= p_nxt;
		end
	end
endmodule // t16_prescale
`default_nettype wire

// ### tb/t16_trig_src.sv
`timescale 1ns/100ps
`default_nettype none
// far-side source of trigger edges and watch-timer ticks
module t16_trig_src (
	input wire logic pclk,
	output logic trig,
	output logic watch_tick
);
	// watch tick spacing in clocks, zero stops the ticks
	int watch_per;
	// cycles since the last watch tick
	int wcnt;
	initial begin
		trig = 1'b0;
		watch_tick = 1'b0;
		watch_per = 0;
		wcnt = 0;
	end
	// one-cycle watch tick every watch_per clocks
	always @(posedge pclk) begin
		if (watch_per > 0 && wcnt >= watch_per - 1) begin
			watch_tick <= 1'b1;
			wcnt <= 0;
		end else begin
			watch_tick <= 1'b0;
			wcnt <= (watch_per > 0) ? wcnt + 1 : 0;
		end
	end
	task automatic pulses(input int n, input int hi, input int lo);
		repeat (n) begin
			trig <= 1'b1;
			repeat (hi) @(posedge pclk);
			trig <= 1'b0;
			repeat (lo) @(posedge pclk);
		end
	endtask
	// single-cycle spike, too short to qualify
	task automatic glitch();
		trig <= 1'b1;
		@(posedge pclk);
		trig <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // t16_trig_src
`default_nettype wire

// ### tb/timer16_event_square_oneshot_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_event_square_oneshot_tb import t16_pkg::*;;
	// one expected read answer
	typedef struct {logic [31:0] d; logic e; string name;} t16_rd_note_s;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ext_trigger_in, watch_tick, timer_out_pin;
	logic primary_match_irq, secondary_match_irq, ext_edge_irq;
	// expected reads and expected pin high widths
	t16_rd_note_s rq[$];
	int wq[$];
	int mismatches, checks_done, cyc, t_rise, n_pri, n_sec, n_edge, i, k, p, s;
	logic pin_q, armed;
	logic [1:0] es_tab [4] = '{T16_ES_FALL, T16_ES_RISE, T16_ES_BOTH, T16_ES_NONE};
	int ex_tab [4] = '{3, 3, 6, 0};
	logic [7:0] clk_tab [4] = '{8'h10, 8'h04, 8'h02, 8'h01};
	int per_tab [4] = '{1, 4, 3, 8};
	t16_timer DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trigger_in(ext_trigger_in),
		.watch_tick(watch_tick), .timer_out_pin(timer_out_pin),
		.primary_match_irq(primary_match_irq), .secondary_match_irq(secondary_match_irq),
		.ext_edge_irq(ext_edge_irq));
	t16_trig_src src (.pclk(pclk), .trig(ext_trigger_in), .watch_tick(watch_tick));
	// free-running bench clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic conclude();
		if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// single comparison point
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			check("pready wait", 0, 1);
			conclude();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	// note the answer, then read
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input string nm,
		input logic e = 1'b0);
		t16_rd_note_s n;
		n.d = d;
		n.e = e;
		n.name = nm;
		rq.push_back(n);
		apb(a, 1'b0, 32'h0);
	endtask
	// bounded wait for all pin widths to be seen
	task automatic wait_empty(input int lim);
		int n;
		for (n = 0; n < lim && wq.size() > 0; n++) @(posedge pclk);
		if (wq.size() > 0) begin
			check("pin pulses pending", wq.size(), 0);
			conclude();
		end
	endtask
	// read answers taken at the access edge
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
			check(rq[0].name, prdata, rq[0].d);
			check("slave error", {31'h0, pslverr}, {31'h0, rq[0].e});
			void'(rq.pop_front());
		end
	end
	// pulse counters and pin high width, sampled mid-cycle
	always @(negedge pclk) begin
		cyc++;
		if (primary_match_irq === 1'b1) n_pri++;
		if (secondary_match_irq === 1'b1) n_sec++;
		if (ext_edge_irq === 1'b1) n_edge++;
		if (timer_out_pin === 1'b1 && pin_q !== 1'b1 && wq.size() > 0) begin
			t_rise = cyc;
			armed = 1'b1;
		end
		if (timer_out_pin === 1'b0 && pin_q === 1'b1 && armed) begin
			armed = 1'b0;
			check("pin high width", cyc - t_rise, wq.pop_front());
		end
		pin_q = timer_out_pin;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, armed, pin_q} = '0;
		{mismatches, checks_done, cyc, n_pri, n_sec, n_edge} = '0;
		ce = 1'b1;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(32'h8cb1eec0));
		// reset values and unmapped access
		rd(T16_OFF_PRI, 32'hffff, "primary reset");
		rd(T16_OFF_COUNT, 32'h0, "count reset");
		rd(T16_OFF_MODE, 32'h0, "mode reset");
		wr(8'h24, 32'h5);
		rd(8'h24, 32'h0, "unmapped", 1'b1);
		p = 8 + ($urandom % 8);
		wr(T16_OFF_CLKSEL, {30'h0, T16_SRC_EXT});
		wr(T16_OFF_PRI, p);
		for (k = 0; k < 4; k++) begin
			wr(T16_OFF_MODE, 32'h0);
			wr(T16_OFF_EXTIRQ, {28'h0, es_tab[k], 2'h0});
			wr(T16_OFF_MODE, 32'h0c);
			n_edge = 0;
			src.pulses(3, 4, 4);
			src.glitch();
			repeat (6) @(posedge pclk);
			rd(T16_OFF_COUNT, ex_tab[k], "event count");
			check("edge requests", n_edge, ex_tab[k]);
		end
		wr(T16_OFF_MODE, 32'h0);
		wr(T16_OFF_EXTIRQ, {28'h0, T16_ES_RISE, 2'h0});
		wr(T16_OFF_MODE, 32'h0c);
		n_pri = 0;
		src.pulses(p + 1, 4, 4);
		repeat (6) @(posedge pclk);
		rd(T16_OFF_COUNT, 32'h0, "count after match");
		check("primary requests", n_pri, 1);
		wr(T16_OFF_PRI, 32'h3);
		for (k = 0; k < 4; k++) begin
			wr(T16_OFF_MODE, 32'h0);
			wr(T16_OFF_OUTCTL, 32'h0);
			wr(T16_OFF_CLKSEL, clk_tab[k]);
			wr(T16_OFF_OUTCTL, 32'h3);
			wq.push_back(4 * per_tab[k]);
			wq.push_back(4 * per_tab[k]);
			if (k == 2) src.watch_per = 3;
			wr(T16_OFF_MODE, 32'h0c);
			if (k == 3) src.pulses(24, 4, 4);
			wait_empty(3000);
			src.watch_per = 0;
		end
		p = 20 + ($urandom % 20);
		s = 6 + ($urandom % 10);
		wr(T16_OFF_MODE, 32'h0);
		wr(T16_OFF_OUTCTL, 32'h0);
		wr(T16_OFF_CLKSEL, 32'h10);
		wr(T16_OFF_PRI, p);
		wr(T16_OFF_SEC, s);
		wr(T16_OFF_OUTCTL, 32'h5);
		wr(T16_OFF_MODE, 32'h0c);
		n_pri = 0;
		n_sec = 0;
		wq.push_back(p - s);
		wr(T16_OFF_OUTCTL, 32'h45);
		wait_empty(200);
		check("secondary requests", n_sec, 1);
		check("primary at pulse end", n_pri, 1);
		repeat (p + 3) @(posedge pclk);
		check("count keeps running", n_pri, 2);
		rd(T16_OFF_OUTCTL, 32'h5, "trigger bit reads 0");
		wq.push_back(p - s);
		wr(T16_OFF_OUTCTL, 32'h45);
		wait_empty(200);
		wr(T16_OFF_MODE, 32'h0);
		repeat (10) @(posedge pclk);
		rd(T16_OFF_COUNT, 32'h0, "stopped count");
		wr(T16_OFF_PRI, 32'h28);
		wr(T16_OFF_SEC, 32'h0a);
		wr(T16_OFF_MODE, 32'h08);
		wq.push_back(30);
		src.pulses(2, 4, 12);
		wait_empty(200);
		wr(T16_OFF_MODE, 32'h0);
		wr(T16_OFF_OUTCTL, 32'h0);
		wr(T16_OFF_CLKSEL, {30'h0, T16_SRC_EXT});
		wr(T16_OFF_CAPCMP, 32'h1);
		wr(T16_OFF_MODE, 32'h0c);
		src.pulses(3, 4, 4);
		rd(T16_OFF_SEC, 32'h2, "captured count");
		n_edge = 0;
		fork
			src.pulses(1, 4, 4);
			begin
				repeat (2) @(posedge pclk);
				rd(T16_OFF_SEC, 32'h2, "read during edge");
			end
		join
		rd(T16_OFF_SEC, 32'h2, "capture held");
		check("edge during read", n_edge, 1);
		wr(T16_OFF_CAPCMP, 32'h0);
		wr(T16_OFF_CLKSEL, 32'h10);
		wr(T16_OFF_MODE, 32'h0);
		wr(T16_OFF_OUTCTL, 32'h0);
		wr(T16_OFF_PRI, 32'h40);
		n_pri = 0;
		wr(T16_OFF_MODE, 32'h0c);
		repeat (30) @(posedge pclk);
		wr(T16_OFF_PRI, 32'h10);
		repeat (200) @(posedge pclk);
		check("no early match", n_pri, 0);
		rd(T16_OFF_MODE, 32'h0c, "overflow not yet");
		for (i = 0; i < 70000 && n_pri == 0; i++) @(posedge pclk);
		check("match after wrap", {31'h0, i > 60000 && n_pri == 1}, 1);
		rd(T16_OFF_MODE, 32'h0d, "overflow set");
		wr(T16_OFF_MODE, 32'h0c);
		rd(T16_OFF_MODE, 32'h0c, "overflow cleared");
		conclude();
	end
endmodule // timer16_event_square_oneshot_tb
`default_nettype wire
